/* design/ivf_consts.svh */
// Command codes, field positions, reset values and timing for the input voltage supervisor
`ifndef IVF_CONSTS_SVH
`define IVF_CONSTS_SVH

// Command codes
`define IVF_CMD_OVF          8'h55
`define IVF_CMD_ACTION       8'h56
`define IVF_CMD_OVW          8'h57
`define IVF_CMD_UVW          8'h58
`define IVF_CMD_UVF          8'h59

// Fault action fields
`define IVF_MODE_MSB         7
`define IVF_MODE_LSB         6
`define IVF_RETRY_MSB        5
`define IVF_RETRY_LSB        3
`define IVF_DELAY_MSB        2
`define IVF_DELAY_LSB        0
`define IVF_MODE_DIS_RETRY   2'h2
`define IVF_RETRY_NONE       3'h0
`define IVF_RETRY_FOREVER    3'h7

// Status bit positions
`define IVF_ST_OVF           0
`define IVF_ST_OVW           1
`define IVF_ST_UVW           2
`define IVF_ST_UVF           3

// Reset values
`define IVF_OV_RESET         16'h7bff
`define IVF_UV_RESET         16'h0000
`define IVF_ACTION_RESET     8'h80

// Timing
`define IVF_CLK_MHZ          50
`define IVF_MS_US            1000
`define IVF_MS_CYCLES        (`IVF_MS_US * `IVF_CLK_MHZ)
`define IVF_RETRY_STEP_MS    35

`endif

/* design/ivf_pkg.sv */
// Types shared by the input voltage supervisor
package ivf_pkg;
   typedef enum logic [1:0] {
      ST_IDLE    = 2'h0,
      ST_ON      = 2'h1,
      ST_DELAY   = 2'h2,
      ST_LATCHED = 2'h3
   } ivf_state_e;

   typedef logic [15:0] ivf_word_t;
endpackage

/* design/ivf_retry_if.sv */
// Handshake between the restart controller and the retry delay timer
`timescale 1ns/1ps
interface ivf_retry_if;
   logic       start;
   logic [2:0] delay_sel;
   logic       done;
   logic       busy;

   modport ctrl  (output start, output delay_sel, input done, input busy);
   modport timer (input start, input delay_sel, output done, output busy);
endinterface

/* design/ivf_retry_timer.sv */
// Retry delay timer in 35 ms steps, driven by a 1 ms enable
`timescale 1ns/1ps
`include "ivf_consts.svh"
module ivf_retry_timer #(
   parameter int MS_CYCLES = `IVF_MS_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Controller side
   ivf_retry_if.timer tmr
);
   logic [15:0] div;
   logic [8:0]  ms;
   logic [8:0]  target;
   logic        busy;
   logic        tick;

   // One-cycle 1 ms enable while running
   assign tick      = busy && (div == 16'(MS_CYCLES - 1));
   assign tmr.done  = tick && (ms == target - 9'h001);
   assign tmr.busy  = busy;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         busy <= 1'b0;
      end else if (tmr.start) begin
         busy <= 1'b1;
      end else if (tmr.done) begin
         busy <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || tmr.start) begin
         div <= 16'h0000;
      end else if (busy) begin
         div <= tick ? 16'h0000 : div + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || tmr.start) begin
         ms <= 9'h000;
      end else if (tick) begin
         ms <= ms + 9'h001;
      end
   end

   // Delay is (field + 1) steps of 35 ms
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         target <= 9'h000;
      end else if (tmr.start) begin
         target <= 9'(({6'h00, tmr.delay_sel} + 9'h001) * 9'(`IVF_RETRY_STEP_MS));
      end
   end
endmodule

/* design/ivf_top.sv */
// Input voltage fault supervisor: threshold registers, comparators, fault action and restart
//
// Function
// - Over-voltage fault threshold word at 0x55
// - Fault action byte at 0x56, byte access
// - Any mode: alert low, fault status set
// - Mode 10: output off, then restart attempts
// - Retry field sets number of restart attempts
// - Retry 111: retry without limit
// - Restart spacing is (delay+1) times 35 ms
// - Over-voltage warning threshold word at 0x57
// - Under-voltage warning threshold word at 0x58
// - Under-voltage fault threshold word at 0x59
`timescale 1ns/1ps
`include "ivf_consts.svh"
module ivf_top #(
   parameter int MS_CYCLES = `IVF_MS_CYCLES
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        srst,
   // Command port
   input  wire logic        cmd_valid,
   input  wire logic        cmd_write,
   input  wire logic        cmd_word,
   input  wire logic [7:0]  cmd_code,
   input  wire logic [15:0] cmd_wdata,
   output logic             cmd_done,
   output logic             cmd_err,
   output logic [15:0]      cmd_rdata,
   // Measurement
   input  wire logic        vin_sample_valid,
   input  wire logic [15:0] vin_sample,
   // Power stage control
   input  wire logic        enable_request,
   input  wire logic        other_fault,
   output logic             output_enable,
   // Status and alert
   input  wire logic        status_clear,
   output logic [3:0]       status,
   output logic             alert_line_n
);
   localparam logic [15:0] THR_RESET [4] = '{`IVF_OV_RESET, `IVF_OV_RESET,
                                             `IVF_UV_RESET, `IVF_UV_RESET};

   ivf_pkg::ivf_word_t   thr [4];
   logic [7:0]           input_overvoltage_fault_action;
   ivf_pkg::ivf_word_t   input_overvoltage_fault_threshold;
   ivf_pkg::ivf_word_t   input_overvoltage_warning_threshold;
   ivf_pkg::ivf_word_t   input_undervoltage_warning_threshold;
   ivf_pkg::ivf_word_t   input_undervoltage_fault_threshold;
   logic [3:0]           dec;
   logic                 cmd_ok;
   logic signed [42:0]   vin_fix;
   logic [3:0]           hit;
   logic [3:0]           next_status;
   logic                 ov_level;
   logic                 fault_evt;
   logic                 run_ok;
   logic                 latch_now;
   logic [1:0]           act_mode;
   logic [2:0]           act_retry;
   logic [2:0]           attempts;
   ivf_pkg::ivf_state_e  state;
   ivf_pkg::ivf_state_e  next_state;
   ivf_retry_if          rt ();

   // Returns {mapped, word access, threshold index}
   function automatic logic [3:0] cmd_decode(input logic [7:0] code);
      case (code)
         `IVF_CMD_OVF:    cmd_decode = 4'hc;
         `IVF_CMD_ACTION: cmd_decode = 4'h8;
         `IVF_CMD_OVW:    cmd_decode = 4'hd;
         `IVF_CMD_UVW:    cmd_decode = 4'he;
         `IVF_CMD_UVF:    cmd_decode = 4'hf;
         default:         cmd_decode = 4'h0;
      endcase
   endfunction

   // Linear word to fixed point scaled by 2^16, for ordered compare
   function automatic logic signed [42:0] lin_to_fix(input logic [15:0] w);
      logic signed [42:0] m;
      m          = {{32{w[10]}}, w[10:0]};
      lin_to_fix = m <<< {~w[15], w[14:11]};
   endfunction

   assign dec    = cmd_decode(cmd_code);
   assign cmd_ok = dec[3] && (dec[2] == cmd_word);

   assign input_overvoltage_fault_threshold    = thr[0];
   assign input_overvoltage_warning_threshold  = thr[1];
   assign input_undervoltage_warning_threshold = thr[2];
   assign input_undervoltage_fault_threshold   = thr[3];

   // Threshold words
   for (genvar g = 0; g < 4; g++) begin : g_thr
      always_ff @(posedge clk_sys) begin
         if (srst) begin
            thr[g] <= THR_RESET[g];
         end else if (cmd_valid && cmd_write && cmd_ok && dec[2] && dec[1:0] == 2'(g)) begin
            thr[g] <= cmd_wdata;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         input_overvoltage_fault_action <= `IVF_ACTION_RESET;
      end else if (cmd_valid && cmd_write && cmd_ok && !dec[2]) begin
         input_overvoltage_fault_action <= cmd_wdata[7:0];
      end
   end

   // Answer one cycle after the request
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cmd_done  <= 1'b0;
         cmd_err   <= 1'b0;
         cmd_rdata <= 16'h0000;
      end else begin
         cmd_done <= cmd_valid;
         cmd_err  <= cmd_valid && !cmd_ok;
         if (cmd_valid && !cmd_write) begin
            if (!cmd_ok) begin
               cmd_rdata <= 16'h0000;
            end else if (dec[2]) begin
               cmd_rdata <= thr[dec[1:0]];
            end else begin
               cmd_rdata <= {8'h00, input_overvoltage_fault_action};
            end
         end
      end
   end

   // Comparators
   assign vin_fix          = lin_to_fix(vin_sample);
   assign hit[`IVF_ST_OVF] = vin_fix > lin_to_fix(thr[0]);
   assign hit[`IVF_ST_OVW] = vin_fix > lin_to_fix(thr[1]);
   assign hit[`IVF_ST_UVW] = vin_fix < lin_to_fix(thr[2]);
   assign hit[`IVF_ST_UVF] = vin_fix < lin_to_fix(thr[3]);
   assign fault_evt        = vin_sample_valid && hit[`IVF_ST_OVF];

   // Sticky status, a new event wins over the clear
   assign next_status = (status & ~{4{status_clear}}) | ({4{vin_sample_valid}} & hit);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         status       <= 4'h0;
         alert_line_n <= 1'b1;
      end else begin
         status       <= next_status;
         alert_line_n <= ~|next_status;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ov_level <= 1'b0;
      end else if (vin_sample_valid) begin
         ov_level <= hit[`IVF_ST_OVF];
      end
   end

   // Restart control
   assign act_mode     = input_overvoltage_fault_action[`IVF_MODE_MSB:`IVF_MODE_LSB];
   assign act_retry    = input_overvoltage_fault_action[`IVF_RETRY_MSB:`IVF_RETRY_LSB];
   assign rt.delay_sel = input_overvoltage_fault_action[`IVF_DELAY_MSB:`IVF_DELAY_LSB];
   assign run_ok       = enable_request && !other_fault;
   // Budget used up; >= also covers a count lowered while attempts are pending
   assign latch_now    = (act_retry != `IVF_RETRY_FOREVER)
                         && (attempts >= act_retry);

   always_comb begin
      next_state = state;
      rt.start   = 1'b0;
      case (state)
         ivf_pkg::ST_IDLE: begin
            if (run_ok) begin
               next_state = ivf_pkg::ST_ON;
            end
         end
         ivf_pkg::ST_ON: begin
            if (!run_ok) begin
               next_state = ivf_pkg::ST_IDLE;
            end else if (fault_evt && act_mode == `IVF_MODE_DIS_RETRY) begin
               if (latch_now) begin
                  next_state = ivf_pkg::ST_LATCHED;
               end else begin
                  next_state = ivf_pkg::ST_DELAY;
                  rt.start   = 1'b1;
               end
            end
         end
         ivf_pkg::ST_DELAY: begin
            if (!run_ok) begin
               next_state = ivf_pkg::ST_IDLE;
            end else if (rt.done) begin
               next_state = ivf_pkg::ST_ON;
            end
         end
         ivf_pkg::ST_LATCHED: begin
            if (!enable_request || (status_clear && !ov_level)) begin
               next_state = ivf_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = ivf_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state         <= ivf_pkg::ST_IDLE;
         output_enable <= 1'b0;
      end else begin
         state         <= next_state;
         output_enable <= (next_state == ivf_pkg::ST_ON);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         attempts <= 3'h0;
      end else if (state == ivf_pkg::ST_IDLE || state == ivf_pkg::ST_LATCHED) begin
         attempts <= 3'h0;
      end else if (state == ivf_pkg::ST_DELAY && next_state == ivf_pkg::ST_ON) begin
         attempts <= attempts + 3'h1;
      end
   end

   ivf_retry_timer #(
      .MS_CYCLES (MS_CYCLES)
   ) u_timer (
      .clk_sys (clk_sys),
      .srst    (srst),
      .tmr     (rt.timer)
   );

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   logic [31:0] dly_cnt;
   logic        trip;
   always_ff @(posedge clk_sys) begin
      if (srst || state != ivf_pkg::ST_DELAY) begin
         dly_cnt <= 32'h0000_0000;
      end else begin
         dly_cnt <= dly_cnt + 32'h0000_0001;
      end
   end
   assign trip = state == ivf_pkg::ST_ON && run_ok && fault_evt && act_mode == `IVF_MODE_DIS_RETRY;

   a_ovf_write: assert property (cmd_valid && cmd_write && cmd_word && cmd_code == 8'h55
      |=> input_overvoltage_fault_threshold == $past(cmd_wdata))
      else $error("fault threshold write lost");
   a_action_byte: assert property (cmd_valid && !cmd_write && !cmd_word
      && cmd_code == 8'h56
      |=> cmd_done && !cmd_err && cmd_rdata == {8'h00, input_overvoltage_fault_action})
      else $error("action byte read wrong");
   a_fault_alert: assert property (fault_evt |=> !alert_line_n && status[`IVF_ST_OVF])
      else $error("fault did not raise alert");
   a_mode_off: assert property (trip |=> !output_enable)
      else $error("output stayed on after fault");
   a_retry_limit: assert property (trip && latch_now |=> state == ivf_pkg::ST_LATCHED)
      else $error("retry budget not enforced");
   a_no_retry: assert property (trip && act_retry == `IVF_RETRY_NONE
      |=> state == ivf_pkg::ST_LATCHED ##1 !output_enable)
      else $error("restart with zero retries");
   a_retry_forever: assert property (trip && act_retry == `IVF_RETRY_FOREVER
      |=> state == ivf_pkg::ST_DELAY)
      else $error("unlimited retry stopped");
   a_retry_delay: assert property (state == ivf_pkg::ST_DELAY
      && next_state == ivf_pkg::ST_ON
      |-> dly_cnt == 32'((32'(rt.delay_sel) + 1) * `IVF_RETRY_STEP_MS * MS_CYCLES - 1))
      else $error("retry delay length wrong");
   a_delay_timer: assert property (state == ivf_pkg::ST_DELAY |-> rt.busy)
      else $error("retry timer idle in delay");
   a_ovw_read: assert property (cmd_valid && !cmd_write && cmd_word && cmd_code == 8'h57
      |=> cmd_rdata == $past(input_overvoltage_warning_threshold))
      else $error("warning threshold read wrong");
   a_uvw_write: assert property (cmd_valid && cmd_write && cmd_word && cmd_code == 8'h58
      |=> input_undervoltage_warning_threshold == $past(cmd_wdata))
      else $error("uv warning write lost");
   a_uvf_write: assert property (cmd_valid && cmd_write && cmd_word && cmd_code == 8'h59
      |=> input_undervoltage_fault_threshold == $past(cmd_wdata))
      else $error("uv fault write lost");
   a_uv_compare: assert property (vin_sample_valid
      && vin_fix < lin_to_fix(input_undervoltage_fault_threshold)
      |=> status[`IVF_ST_UVF] && !alert_line_n)
      else $error("uv fault not flagged");

   c_restart: cover property (state == ivf_pkg::ST_DELAY ##1 state == ivf_pkg::ST_ON);
   c_latched: cover property (state == ivf_pkg::ST_ON ##1 state == ivf_pkg::ST_LATCHED);
   c_cmd_ok:  cover property (cmd_done && !cmd_err);
   c_alert:   cover property ($fell(alert_line_n));
endmodule

/* sim/ivf_host.sv */
// Command port host model that issues one transfer at a time
`timescale 1ns/1ps
module ivf_host (
   // Clock
   input  wire logic        clk_sys,
   // Request side
   output logic             cmd_valid,
   output logic             cmd_write,
   output logic             cmd_word,
   output logic [7:0]       cmd_code,
   output logic [15:0]      cmd_wdata,
   // Answer side
   input  wire logic        cmd_done,
   input  wire logic        cmd_err,
   input  wire logic [15:0] cmd_rdata
);
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_word  = 1'b0;
      cmd_code  = 8'h00;
      cmd_wdata = 16'h0000;
   end

   // One request pulse, answer taken in the fixed answer cycle
   task automatic xfer(input logic w, input logic wd, input logic [7:0] code,
                       input logic [15:0] d, output logic [15:0] rd,
                       output logic err, output logic dn);
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_word  <= wd;
      cmd_code  <= code;
      cmd_wdata <= wd ? d : {8'h00, d[7:0]};
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      // Released qualifiers show a changed pattern, not the old value
      cmd_code  <= ~code;
      cmd_wdata <= ~d;
      #1;
      rd  = cmd_rdata;
      err = cmd_err;
      dn  = cmd_done;
   endtask
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the input voltage fault supervisor
`timescale 1ns/1ps
`include "ivf_consts.svh"
module tb_top;
   localparam int M = 2;
   logic        clk_sys, srst, vin_sample_valid, enable_request, other_fault;
   logic        status_clear, cmd_valid, cmd_write, cmd_word, cmd_done, cmd_err;
   logic        output_enable, alert_line_n, er, dn;
   logic [7:0]  cmd_code;
   logic [15:0] cmd_wdata, cmd_rdata, vin_sample, rd, v;
   logic [3:0]  status, st;
   logic [15:0] mdl [5];
   int          n_fail, check_count, n;
   integer      seed;

   ivf_host host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_word(cmd_word), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
      .cmd_done(cmd_done), .cmd_err(cmd_err), .cmd_rdata(cmd_rdata));

   ivf_top #(.MS_CYCLES(M)) uut (.clk_sys(clk_sys), .srst(srst), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_word(cmd_word), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .cmd_done(cmd_done), .cmd_err(cmd_err),
      .cmd_rdata(cmd_rdata), .vin_sample_valid(vin_sample_valid),
      .vin_sample(vin_sample), .enable_request(enable_request),
      .other_fault(other_fault), .output_enable(output_enable),
      .status_clear(status_clear), .status(status), .alert_line_n(alert_line_n));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask

   task tally_and_finish;
      if (n_fail == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Register access against the model table
   task acc(input logic w, input logic wd, input logic [7:0] c, input logic [15:0] d);
      logic ok;
      ok = (c >= 8'h55) && (c <= 8'h59) && (wd == (c != 8'h56));
      host.xfer(w, wd, c, d, rd, er, dn);
      chk(16'(dn), 16'h0001, "done");
      chk(16'(er), 16'(!ok), "err");
      if (ok && w) mdl[c - 8'h55] = wd ? d : {8'h00, d[7:0]};
      if (!w) chk(rd, ok ? mdl[c - 8'h55] : 16'h0000, "rdata");
   endtask

   // Sample with optional clear; thresholds use plain positive words
   task smp(input logic [15:0] s, input logic clr);
      @(posedge clk_sys);
      vin_sample_valid <= 1'b1;
      vin_sample       <= s;
      status_clear     <= clr;
      @(posedge clk_sys);
      vin_sample_valid <= 1'b0;
      status_clear     <= 1'b0;
      vin_sample       <= ~s;
      #1;
      if (clr) st = 4'h0;
      st |= {s < mdl[4], s < mdl[3], s > mdl[2], s > mdl[0]};
      chk(16'(status), 16'(st), "status");
      chk(16'(alert_line_n), 16'(st == 4'h0), "alert");
   endtask

   task wait_on;
      n = 0;
      repeat (2000) begin
         @(posedge clk_sys);
         #1;
         n++;
         if (output_enable === 1'b1) break;
      end
   endtask

   task cyc(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      tally_and_finish;
   end

   initial begin
      srst = 1'b1;
      vin_sample_valid = 1'b0;
      vin_sample = 16'h0000;
      enable_request = 1'b0;
      other_fault = 1'b0;
      status_clear = 1'b0;
      n_fail = 0;
      check_count = 0;
      seed = 32'h5bda03ca;
      st = 4'h0;
      mdl = '{`IVF_OV_RESET, {8'h00, `IVF_ACTION_RESET}, `IVF_OV_RESET, `IVF_UV_RESET,
              `IVF_UV_RESET};
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      #1;
      chk(16'({output_enable, alert_line_n, status}), 16'h0010, "reset");
      for (int i = 0; i < 5; i++) begin
         acc(1'b0, i != 1, 8'(8'h55 + i), 16'h0000);
      end
      for (int i = 0; i < 5; i++) begin
         v = 16'($random(seed));
         acc(1'b1, i != 1, 8'(8'h55 + i), v);
         acc(1'b0, i != 1, 8'(8'h55 + i), 16'h0000);
      end
      acc(1'b1, 1'b0, 8'h55, v);
      acc(1'b1, 1'b1, 8'h56, v);
      acc(1'b0, 1'b1, 8'h56, 16'h0000);
      acc(1'b1, 1'b1, 8'h5a, v);
      acc(1'b0, 1'b1, 8'h54, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         acc(1'b0, i != 1, 8'(8'h55 + i), 16'h0000);
      end
      acc(1'b1, 1'b1, 8'h55, 16'h0300);
      acc(1'b1, 1'b1, 8'h57, 16'h0200);
      acc(1'b1, 1'b1, 8'h58, 16'h0100);
      acc(1'b1, 1'b1, 8'h59, 16'h0080);
      for (int i = 0; i < 40; i++) begin
         smp(16'($random(seed)) & 16'h03ff, 1'($random(seed)));
      end
      // Alert only mode keeps the output on
      acc(1'b1, 1'b0, 8'h56, 16'h0000);
      enable_request <= 1'b1;
      cyc(3);
      smp(16'h0350, 1'b1);
      chk(16'(output_enable), 16'h0001, "mode00 on");
      // Disable without retry, then clear
      acc(1'b1, 1'b0, 8'h56, 16'h0080);
      smp(16'h0350, 1'b1);
      chk(16'(output_enable), 16'h0000, "off at fault");
      cyc(80);
      chk(16'(output_enable), 16'h0000, "stays off");
      // A clear while the voltage is still high must not release
      smp(16'h0350, 1'b1);
      cyc(3);
      chk(16'(output_enable), 16'h0000, "clear during fault");
      smp(16'h0150, 1'b0);
      cyc(3);
      chk(16'(output_enable), 16'h0000, "no clear yet");
      smp(16'h0150, 1'b1);
      cyc(3);
      chk(16'(output_enable), 16'h0001, "on after clear");
      // Two retries 70 ms apart, then latched
      acc(1'b1, 1'b0, 8'h56, 16'h0091);
      for (int k = 0; k < 2; k++) begin
         smp(16'h0350, 1'b1);
         chk(16'(output_enable), 16'h0000, "off");
         wait_on;
         chk(16'(n), 16'(2 * 35 * M), "delay");
      end
      smp(16'h0350, 1'b1);
      cyc(2 * 35 * M + 5);
      chk(16'(output_enable), 16'h0000, "latched");
      enable_request <= 1'b0;
      cyc(2);
      enable_request <= 1'b1;
      cyc(3);
      chk(16'(output_enable), 16'h0001, "on after re-enable");
      // Unlimited retries across every delay code
      for (int d = 0; d < 8; d++) begin
         acc(1'b1, 1'b0, 8'h56, 16'(16'h00b8 + d));
         smp(16'h0350, 1'b1);
         wait_on;
         chk(16'(n), 16'((d + 1) * 35 * M), "delay code");
      end
      smp(16'h0350, 1'b1);
      other_fault <= 1'b1;
      cyc(35 * 8 * M + 5);
      chk(16'(output_enable), 16'h0000, "other fault stops");
      other_fault <= 1'b0;
      cyc(4);
      chk(16'(output_enable), 16'h0001, "enable again");
      tally_and_finish;
   end
endmodule
